// File: testbench/amcfg_motor_model.sv
`default_nettype none
module amcfg_motor_model #(
	parameter int NAXES = 4
) (
	input wire logic core_clk_i,
	input wire logic [NAXES-1:0] pulse_a_i,
	input wire logic [NAXES-1:0] fault_req_i,
	output logic [NAXES-1:0] fault_n_o,
	output logic [NAXES-1:0] settled_n_o,
	output logic [NAXES-1:0] enc_a_o,
	output logic [NAXES-1:0] enc_b_o,
	output int pulse_cnt_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [NAXES-1:0] prev_q = '0;
	logic [1:0] phase_q [NAXES] = '{default: 2'h0};
	int idle_q [NAXES] = '{default: 0};
	int cnt_q = 0;
	assign pulse_cnt_o = cnt_q;
	assign fault_n_o = ~fault_req_i;
	always_comb begin
		for (int i = 0; i < NAXES; i++) begin
			// phase a leads on plus steps
			enc_a_o[i] = phase_q[i][1] ^ phase_q[i][0];
			enc_b_o[i] = phase_q[i][1];
			// settles four cycles after last pulse
			settled_n_o[i] = idle_q[i] < 4;
		end
	end
	always @(posedge core_clk_i) begin
		prev_q <= pulse_a_i;
		for (int i = 0; i < NAXES; i++) begin
			if (pulse_a_i[i] && !prev_q[i]) begin
				phase_q[i] <= phase_q[i] + 2'h1;
				idle_q[i] <= 0;
			end else if (idle_q[i] < 8) begin
				idle_q[i] <= idle_q[i] + 1;
			end
		end
		if (pulse_a_i[0] && !prev_q[0]) begin
			cnt_q <= cnt_q + 1;
		end
	end
endmodule : amcfg_motor_model
`default_nettype wire

// File: testbench/amcfg_top_assertions.sv
`default_nettype none
module amcfg_top_chk #(
	parameter int NAXES = 4
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic avs_waitrequest,
	input wire logic cmd_wait_n_o,
	input wire logic [7:0] irq_src_en_o [NAXES]
);
	logic [3:0] sel_q;
	logic cmd_wr;
	logic rst_wr;
	logic md1_wr;
	logic irq_any;
	logic [7:0] wd_hi;
	assign cmd_wr = avs_write && avs_address == 4'h0;
	assign rst_wr = cmd_wr && avs_byteenable[1] && avs_writedata[15:0] == 16'h8000;
	assign md1_wr = avs_write && avs_address == 4'h1 && avs_byteenable[1];
	assign wd_hi = avs_writedata[15:8];
	always_comb begin
		irq_any = 1'b0;
		for (int i = 0; i < NAXES; i++) begin
			irq_any = irq_any | (|irq_src_en_o[i]);
		end
	end
	// Axes chosen by the last select command
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || rst_wr) begin
			sel_q <= 4'h0;
		end else if (cmd_wr && avs_byteenable[1:0] == 2'h3 && avs_writedata[6:0] == 7'h0f) begin
			sel_q <= avs_writedata[11:8];
		end
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	chk_write_nowait: assert property (avs_write |-> !avs_waitrequest)
		else $error("write stalled");
	chk_read_stall: assert property (avs_read && !$past(avs_read) |-> avs_waitrequest)
		else $error("read not stalled in its first cycle");
	chk_cmd_busy: assert property (cmd_wr && avs_byteenable[0] && !rst_wr
		|=> !cmd_wait_n_o ##[1:5] cmd_wait_n_o)
		else $error("command wait length wrong");
	chk_reset_busy: assert property (rst_wr |=> !cmd_wait_n_o ##[1:17] cmd_wait_n_o)
		else $error("reset wait length wrong");
	chk_reset_clear: assert property (rst_wr |-> ##2 !irq_any)
		else $error("mode bits survive device reset");
	chk_irq_load: assert property (md1_wr && sel_q[0] |=> irq_src_en_o[0] == $past(wd_hi))
		else $error("selected axis irq enables not loaded");
	chk_irq_hold: assert property (md1_wr && !sel_q[1] |=> $stable(irq_src_en_o[1]))
		else $error("unselected axis changed");
	chk_busy_cause: assert property ($fell(cmd_wait_n_o) |-> $past(cmd_wr))
		else $error("wait low without command");
endmodule : amcfg_top_chk
bind amcfg_top amcfg_top_chk #(.NAXES(NAXES)) u_chk (
	.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
	.cmd_wait_n_o(cmd_wait_n_o), .irq_src_en_o(irq_src_en_o)
);
`default_nettype wire

// File: testbench/axis_mode_stop_limit_pulse_config_bench.sv
`default_nettype none
module axis_mode_stop_limit_pulse_config_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int N = 4;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [3:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [3:0] avs_byteenable = '0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [3:0] stop_n [N] = '{default: 4'hf};
	logic [N-1:0] lim_n = '1;
	logic [N-1:0] fault_req = '0;
	logic [N-1:0] fault_n, settled_n, enc_a, enc_b, pls_a, pls_b;
	logic cmd_wait_n;
	logic [7:0] irq_en [N];
	logic [3:0] sels [3] = '{4'h5, 4'h2, 4'hc};
	logic [7:0] mir [N] = '{default: 8'h0};
	logic [31:0] exp_q [$];
	logic [7:0] rv;
	int pulse_cnt;
	int miscompares = 0;
	int total_checks = 0;
	int seed = 32'h73096d32;
	int n;
	int c0;
	always #25 core_clk_i = ~core_clk_i;
	amcfg_top #(.NAXES(N)) uut (
		.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .stop_input_n_i(stop_n),
		.limit_plus_in_n_i(lim_n), .limit_minus_in_n_i(lim_n), .servo_fault_in_n_i(fault_n),
		.servo_settled_in_n_i(settled_n), .encoder_in_a_i(enc_a), .encoder_in_b_i(enc_b),
		.pulse_out_a_o(pls_a), .pulse_out_b_o(pls_b), .cmd_wait_n_o(cmd_wait_n),
		.irq_src_en_o(irq_en)
	);
	amcfg_motor_model #(.NAXES(N)) u_motor (
		.core_clk_i(core_clk_i), .pulse_a_i(pls_a), .fault_req_i(fault_req),
		.fault_n_o(fault_n), .settled_n_o(settled_n), .enc_a_o(enc_a), .enc_b_o(enc_b),
		.pulse_cnt_o(pulse_cnt)
	);
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out
	task automatic give_up();
		miscompares++;
		$display("[FAIL] wait expected done seen timeout");
		close_out();
	endtask : give_up
	task automatic bus(input logic [3:0] a, input logic rd, input logic [31:0] d,
		input logic [3:0] be);
		int k = 0;
		@(posedge core_clk_i);
		avs_address <= a;
		avs_read <= rd;
		avs_write <= !rd;
		avs_writedata <= d;
		avs_byteenable <= be;
		@(posedge core_clk_i);
		while (avs_waitrequest) begin
			if (++k > 20) give_up();
			@(posedge core_clk_i);
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(a, 1'b1, 32'h0, 4'hf);
	endtask : rd
	task automatic cmd(input logic [15:0] d, input logic [3:0] be);
		int k = 0;
		bus(4'h0, 1'b0, {16'h0, d}, be);
		@(negedge core_clk_i);
		while (!cmd_wait_n) begin
			if (++k > 40) give_up();
			@(negedge core_clk_i);
		end
	endtask : cmd
	// Read data taken at the edge the transfer completes
	always @(posedge core_clk_i) begin
		if (avs_read && !avs_waitrequest && exp_q.size() > 0) begin
			chk("readdata", exp_q.pop_front(), avs_readdata);
		end
	end
	initial begin
		repeat (3) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		@(negedge core_clk_i);
		foreach (irq_en[i]) chk("irq_reset", 32'h0, irq_en[i]);
		foreach (sels[k]) begin
			cmd({4'h0, sels[k], 8'h0f}, 4'h3);
			rv = 8'($random(seed));
			bus(4'h1, 1'b0, {16'h0, rv, 8'h00}, 4'h3);
			foreach (mir[i]) if (sels[k][i]) mir[i] = rv;
			@(negedge core_clk_i);
			foreach (irq_en[i]) chk("irq_sel", mir[i], irq_en[i]);
		end
		for (int k = 0; k < 2; k++) begin
			cmd(16'h0f0f, 4'h3);
			bus(4'h1, 1'b0, 32'h5a00, 4'h3);
			cmd(16'h8000, k ? 4'h2 : 4'h3);
			@(negedge core_clk_i);
			foreach (irq_en[i]) chk("irq_cmd_reset", 32'h0, irq_en[i]);
		end
		rd(4'h9, 32'h0);
		cmd(16'h010f, 4'h3);
		for (int p = 0; p < 4; p++) begin
			bus(4'h2, 1'b0, {23'h0, p[1], p[0], 7'h40}, 4'h3);
			@(negedge core_clk_i);
			chk("pulse_idle", p[0], pls_a[0]);
			chk("dir_idle", p[1], pls_b[0]);
		end
		bus(4'h2, 1'b0, 32'h1, 4'h3);
		bus(4'h6, 1'b0, 32'h4, 4'hf);
		bus(4'h5, 1'b0, 32'h1, 4'h3);
		n = 0;
		while (pulse_cnt < 5) begin
			if (++n > 50000) give_up();
			@(negedge core_clk_i);
		end
		repeat (3000) @(negedge core_clk_i);
		rd(4'h4, 32'h1);
		c0 = pulse_cnt;
		bus(4'h5, 1'b0, 32'h1, 4'h3);
		repeat (300) @(negedge core_clk_i);
		chk("refused_pulses", c0, pulse_cnt);
		bus(4'h2, 1'b0, 32'h2000, 4'h3);
		bus(4'h4, 1'b0, 32'h0, 4'h3);
		fault_req <= 4'h1;
		repeat (10) @(negedge core_clk_i);
		rd(4'h4, 32'h10);
		rd(4'h6, pulse_cnt);
		fault_req <= 4'h0;
		bus(4'h2, 1'b0, 32'h40, 4'h3);
		bus(4'h1, 1'b0, 32'h1, 4'h3);
		bus(4'h5, 1'b0, 32'h3, 4'h3);
		repeat (20) @(negedge core_clk_i);
		rd(4'h3, 32'h11);
		bus(4'h1, 1'b0, 32'h2, 4'h3);
		stop_n[0] <= 4'he;
		repeat (20) @(negedge core_clk_i);
		rd(4'h3, 32'h10);
		close_out();
	end
endmodule : axis_mode_stop_limit_pulse_config_bench
`default_nettype wire

// File: verilog/amcfg_axis.sv
`default_nettype none
`include "amcfg_consts.svh"
module amcfg_axis (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic clear_i,
	input wire logic start_i,
	input wire logic dir_minus_i,
	input wire logic ramp_i,
	input wire logic stop_hit_i,
	input wire logic decel_req_i,
	input wire logic sudden_req_i,
	input wire logic settle_en_i,
	input wire logic settled_i,
	input wire logic tick_i,
	output logic pulse_o,
	output logic busy_o,
	output logic running_o
);
	import amcfg_pkg::*;
	typedef struct packed {
		amcfg_drv_t st;
		logic dir;
		logic ramp;
		logic pls;
	} amcfg_ax_t;
	amcfg_ax_t s_q, s_d;
	always_comb begin
		s_d = s_q;
		s_d.pls = 1'b0;
		case (s_q.st)
			AMCFG_IDLE: begin
				if (start_i) begin
					s_d.st = AMCFG_RUN;
					s_d.dir = dir_minus_i;
					s_d.ramp = ramp_i;
				end
			end
			AMCFG_RUN: begin
				s_d.pls = tick_i && !s_q.pls;
				if (sudden_req_i || (stop_hit_i && !s_q.ramp) || decel_req_i || stop_hit_i) begin
					s_d.pls = 1'b0;
					s_d.st = settle_en_i ? AMCFG_SETTLE : AMCFG_IDLE;
				end
			end
			AMCFG_SETTLE: begin
				if (settled_i || !settle_en_i)
					s_d.st = AMCFG_IDLE;
			end
			default: s_d.st = AMCFG_IDLE;
		endcase
		if (clear_i) begin
			s_d.st = AMCFG_IDLE;
			s_d.pls = 1'b0;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i)
			s_q <= '{st: AMCFG_IDLE, dir: 1'b0, ramp: 1'b0, pls: 1'b0};
		else
			s_q <= s_d;
	end
	assign pulse_o = s_q.pls;
	assign busy_o = (s_q.st != AMCFG_IDLE);
	assign running_o = (s_q.st == AMCFG_RUN);
endmodule : amcfg_axis
`default_nettype wire

// File: verilog/amcfg_consts.svh
`ifndef AMCFG_CONSTS_SVH
`define AMCFG_CONSTS_SVH
// Register word addresses (Avalon word index, 32-bit data)
`define AMCFG_ADDR_CMD 4'h0
`define AMCFG_ADDR_STOP_IRQ 4'h1
`define AMCFG_ADDR_LIMIT_PULSE 4'h2
`define AMCFG_ADDR_STATUS 4'h3
`define AMCFG_ADDR_AXIS_ERR 4'h4
`define AMCFG_ADDR_DRIVE 4'h5
`define AMCFG_ADDR_SOFT_POS 4'h6
// Command word fields
`define AMCFG_CMD_RESET_BIT 15
`define AMCFG_CMD_AXIS_HI 11
`define AMCFG_CMD_AXIS_LO 8
`define AMCFG_CMD_CODE_HI 6
`define AMCFG_CMD_NOP 7'h0f
`define AMCFG_CMD_RESET_WORD 16'h8000
`define AMCFG_RESET_HIGH_BYTE 8'h80
// Limit/pulse mode fields
`define AMCFG_SLP 0
`define AMCFG_SLM 1
`define AMCFG_LMT_TYPE 2
`define AMCFG_HLP_LVL 3
`define AMCFG_HLM_LVL 4
`define AMCFG_CMP_SRC 5
`define AMCFG_OUT_FMT 6
`define AMCFG_PLS_POL 7
`define AMCFG_DIR_POL 8
`define AMCFG_ENC_TYPE 9
`define AMCFG_DIV_LO 10
`define AMCFG_DIV_HI 11
`define AMCFG_ALM_LVL 12
`define AMCFG_ALM_EN 13
`define AMCFG_INP_LVL 14
`define AMCFG_INP_EN 15
// Drive control word fields
`define AMCFG_DRV_START 0
`define AMCFG_DRV_DIR 1
`define AMCFG_DRV_RAMP 2
// Error status bits
`define AMCFG_ERR_SLP 0
`define AMCFG_ERR_SLM 1
`define AMCFG_ERR_HLP 2
`define AMCFG_ERR_HLM 3
`define AMCFG_ERR_ALM 4
// Timing: busy time after command write
`define AMCFG_CMD_BUSY_NS 250
`define AMCFG_RESET_BUSY_NS 875
`define AMCFG_CLK_NS 50
`define AMCFG_NAXES 4
`endif

// File: verilog/amcfg_pkg.sv
`default_nettype none
package amcfg_pkg;
	typedef logic [15:0] amcfg_word_t;
	typedef logic [3:0] amcfg_axes_t;
	typedef enum logic [2:0] {
		AMCFG_IDLE = 3'b001,
		AMCFG_RUN = 3'b010,
		AMCFG_SETTLE = 3'b100
	} amcfg_drv_t;
endpackage : amcfg_pkg
`default_nettype wire

// File: verilog/amcfg_top.sv
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`default_nettype none
`include "amcfg_consts.svh"
module amcfg_top #(
	parameter int NAXES = `AMCFG_NAXES
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [3:0] stop_input_n_i [NAXES],
	input wire logic [NAXES-1:0] limit_plus_in_n_i,
	input wire logic [NAXES-1:0] limit_minus_in_n_i,
	input wire logic [NAXES-1:0] servo_fault_in_n_i,
	input wire logic [NAXES-1:0] servo_settled_in_n_i,
	input wire logic [NAXES-1:0] encoder_in_a_i,
	input wire logic [NAXES-1:0] encoder_in_b_i,
	output logic [NAXES-1:0] pulse_out_a_o,
	output logic [NAXES-1:0] pulse_out_b_o,
	output logic cmd_wait_n_o,
	output logic [7:0] irq_src_en_o [NAXES]
);
	import amcfg_pkg::*;
	localparam int CMD_BUSY_CYC = `AMCFG_CMD_BUSY_NS / `AMCFG_CLK_NS;
	localparam int RST_BUSY_CYC = `AMCFG_RESET_BUSY_NS / `AMCFG_CLK_NS;
	localparam int SYNC_W = 10;

	typedef struct packed {
		amcfg_axes_t sel;
		logic [NAXES-1:0][15:0] stop_irq;
		logic [NAXES-1:0][15:0] lim_pls;
		logic [NAXES-1:0][4:0] err;
		logic [NAXES-1:0][31:0] lpos;
		logic [NAXES-1:0][31:0] rpos;
		logic [NAXES-1:0][31:0] cmp_p;
		logic [NAXES-1:0][31:0] cmp_m;
		logic [NAXES-1:0][1:0] divc;
		logic [NAXES-1:0][1:0] ab_old;
		logic [NAXES-1:0] dir_out;
		logic [NAXES-1:0] pls_out;
		logic [4:0] busy_cnt;
		logic dev_clear;
		logic [31:0] rdata;
		logic rvalid;
		logic [NAXES-1:0][SYNC_W-1:0] s1;
		logic [NAXES-1:0][SYNC_W-1:0] s2;
	} amcfg_state_t;
	amcfg_state_t s_q, s_d;

	logic [NAXES-1:0] start_w, ramp_w, stop_hit, decel_req, sudden_req;
	logic [NAXES-1:0] settled, pulse_w, drv_busy, running, dir_w;

	function automatic logic act_lvl(input logic pin, input logic level);
		act_lvl = (pin == level);
	endfunction : act_lvl

	function automatic logic [1:0] first_axis(input amcfg_axes_t sel);
		first_axis = 2'd0;
		for (int k = 3; k >= 0; k--) begin
			if (sel[k])
				first_axis = 2'(k);
		end
	endfunction : first_axis

	function automatic logic is_reset(input logic [3:0] be, input logic [15:0] d);
		is_reset = 1'b0;
		if (be[1] && !be[0] && d[15:8] == `AMCFG_RESET_HIGH_BYTE)
			is_reset = 1'b1;
		else if (be[1] && be[0] && d == `AMCFG_CMD_RESET_WORD)
			is_reset = 1'b1;
	endfunction : is_reset

	always_comb begin
		logic [31:0] pos;
		logic [15:0] lp;
		logic [15:0] si;
		logic [SYNC_W-1:0] in;
		logic cnt_up, cnt_dn, ea, eb;
		logic [1:0] ab;
		logic [1:0] ax;
		logic wr;
		pos = 32'h0;
		lp = 16'h0;
		si = 16'h0;
		in = '0;
		cnt_up = 1'b0;
		cnt_dn = 1'b0;
		ea = 1'b0;
		eb = 1'b0;
		ab = 2'b00;
		ax = first_axis(s_q.sel);
		wr = avs_write && !avs_waitrequest;
		s_d = s_q;
		s_d.dev_clear = 1'b0;
		s_d.rvalid = avs_read && !s_q.rvalid;
		start_w = '0;
		ramp_w = '0;
		stop_hit = '0;
		decel_req = '0;
		sudden_req = '0;
		settled = '0;
		dir_w = s_q.dir_out;
		if (s_q.busy_cnt != 5'd0)
			s_d.busy_cnt = s_q.busy_cnt - 5'd1;
		// flag clear; a same-cycle event wins
		if (wr && avs_address == `AMCFG_ADDR_AXIS_ERR) begin
			for (int a = 0; a < NAXES; a++) begin
				if (s_q.sel[a])
					s_d.err[a] = 5'h00;
			end
		end
		for (int a = 0; a < NAXES; a++) begin
			s_d.s1[a] = {encoder_in_b_i[a], encoder_in_a_i[a], servo_settled_in_n_i[a],
				servo_fault_in_n_i[a], limit_minus_in_n_i[a], limit_plus_in_n_i[a],
				stop_input_n_i[a]};
			s_d.s2[a] = s_q.s1[a];
			in = s_q.s2[a];
			lp = s_q.lim_pls[a];
			si = s_q.stop_irq[a];
			pos = lp[`AMCFG_CMP_SRC] ? s_q.rpos[a] : s_q.lpos[a];
			for (int m = 0; m < 4; m++) begin
				if (si[2*m+1] && act_lvl(in[m], si[2*m]))
					stop_hit[a] = 1'b1;
			end
			if (running[a] && !s_q.dir_out[a] && act_lvl(in[4], lp[`AMCFG_HLP_LVL])) begin
				s_d.err[a][`AMCFG_ERR_HLP] = 1'b1;
				if (lp[`AMCFG_LMT_TYPE])
					decel_req[a] = 1'b1;
				else
					sudden_req[a] = 1'b1;
			end
			if (running[a] && s_q.dir_out[a] && act_lvl(in[5], lp[`AMCFG_HLM_LVL])) begin
				s_d.err[a][`AMCFG_ERR_HLM] = 1'b1;
				if (lp[`AMCFG_LMT_TYPE])
					decel_req[a] = 1'b1;
				else
					sudden_req[a] = 1'b1;
			end
			if (lp[`AMCFG_ALM_EN] && act_lvl(in[6], lp[`AMCFG_ALM_LVL])) begin
				s_d.err[a][`AMCFG_ERR_ALM] = 1'b1;
				sudden_req[a] = 1'b1;
			end
			settled[a] = act_lvl(in[7], lp[`AMCFG_INP_LVL]);
			if (lp[`AMCFG_SLP] && running[a] && !s_q.dir_out[a]
					&& $signed(pos) > $signed(s_q.cmp_p[a])) begin
				s_d.err[a][`AMCFG_ERR_SLP] = 1'b1;
				decel_req[a] = 1'b1;
			end
			if (lp[`AMCFG_SLM] && running[a] && s_q.dir_out[a]
					&& $signed(pos) < $signed(s_q.cmp_m[a])) begin
				s_d.err[a][`AMCFG_ERR_SLM] = 1'b1;
				decel_req[a] = 1'b1;
			end
			if (pulse_w[a])
				s_d.lpos[a] = s_q.dir_out[a] ? s_q.lpos[a] - 32'd1 : s_q.lpos[a] + 32'd1;
			ab = {in[9], in[8]};
			ea = ab[0] != s_q.ab_old[a][0];
			eb = ab[1] != s_q.ab_old[a][1];
			s_d.ab_old[a] = ab;
			if (lp[`AMCFG_ENC_TYPE]) begin
				cnt_up = ab[0] && !s_q.ab_old[a][0];
				cnt_dn = ab[1] && !s_q.ab_old[a][1];
			end else begin
				cnt_up = (ea && (ab[0] != ab[1])) || (eb && (ab[0] == ab[1]));
				cnt_dn = (ea && (ab[0] == ab[1])) || (eb && (ab[0] != ab[1]));
			end
			if (!lp[`AMCFG_ENC_TYPE] && (cnt_up || cnt_dn)) begin
				s_d.divc[a] = s_q.divc[a] + 2'd1;
				case ({lp[`AMCFG_DIV_HI], lp[`AMCFG_DIV_LO]})
					2'b00: ;
					2'b01: if (s_q.divc[a][0] == 1'b0) begin
						cnt_up = 1'b0;
						cnt_dn = 1'b0;
					end
					2'b10: if (s_q.divc[a] != 2'b11) begin
						cnt_up = 1'b0;
						cnt_dn = 1'b0;
					end
					default: begin
						cnt_up = 1'b0;
						cnt_dn = 1'b0;
					end
				endcase
			end
			if (cnt_up)
				s_d.rpos[a] = s_q.rpos[a] + 32'd1;
			else if (cnt_dn)
				s_d.rpos[a] = s_q.rpos[a] - 32'd1;
			s_d.pls_out[a] = pulse_w[a];
		end
		// Register writes
		if (wr) begin
			if (avs_address == `AMCFG_ADDR_CMD) begin
				if (is_reset(avs_byteenable, avs_writedata[15:0])) begin
					s_d.dev_clear = 1'b1;
					s_d.busy_cnt = 5'(RST_BUSY_CYC);
				end else if (avs_byteenable[0]) begin
					s_d.busy_cnt = 5'(CMD_BUSY_CYC);
					if (avs_writedata[`AMCFG_CMD_CODE_HI:0] == `AMCFG_CMD_NOP)
						s_d.sel = avs_writedata[`AMCFG_CMD_AXIS_HI:`AMCFG_CMD_AXIS_LO];
				end
			end else if (avs_address == `AMCFG_ADDR_DRIVE) begin
				for (int a = 0; a < NAXES; a++) begin
					if (s_q.sel[a] && avs_writedata[`AMCFG_DRV_START]
							&& !(avs_writedata[`AMCFG_DRV_DIR] ? s_q.err[a][`AMCFG_ERR_SLM]
							: s_q.err[a][`AMCFG_ERR_SLP])) begin
						start_w[a] = 1'b1;
						ramp_w[a] = avs_writedata[`AMCFG_DRV_RAMP];
						s_d.dir_out[a] = avs_writedata[`AMCFG_DRV_DIR];
						dir_w[a] = avs_writedata[`AMCFG_DRV_DIR];
					end
				end
			end else begin
				for (int a = 0; a < NAXES; a++) begin
					if (s_q.sel[a]) begin
						if (avs_address == `AMCFG_ADDR_STOP_IRQ)
							s_d.stop_irq[a] = avs_writedata[15:0];
						else if (avs_address == `AMCFG_ADDR_LIMIT_PULSE)
							s_d.lim_pls[a] = avs_writedata[15:0];
						else if (avs_address == `AMCFG_ADDR_SOFT_POS) begin
							s_d.cmp_p[a] = avs_writedata;
							s_d.cmp_m[a] = avs_writedata;
						end
					end
				end
			end
		end
		if (avs_address == `AMCFG_ADDR_STATUS)
			s_d.rdata = {16'h0, 8'h0, s_q.sel, drv_busy};
		else if (avs_address == `AMCFG_ADDR_AXIS_ERR)
			s_d.rdata = {27'h0, s_q.err[ax]};
		else if (avs_address == `AMCFG_ADDR_STOP_IRQ)
			s_d.rdata = {16'h0, s_q.stop_irq[ax]};
		else if (avs_address == `AMCFG_ADDR_LIMIT_PULSE)
			s_d.rdata = {16'h0, s_q.lim_pls[ax]};
		else if (avs_address == `AMCFG_ADDR_SOFT_POS)
			s_d.rdata = s_q.rpos[ax];
		else
			s_d.rdata = 32'h0;
		if (s_q.dev_clear) begin
			s_d.stop_irq = '0;
			s_d.lim_pls = '0;
			s_d.err = '0;
			s_d.sel = '0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	for (genvar g = 0; g < NAXES; g++) begin : g_ax
		amcfg_axis u_axis (
			.core_clk_i(core_clk_i),
			.rst_n_i(rst_n_i),
			.clear_i(s_q.dev_clear),
			.start_i(start_w[g]),
			.dir_minus_i(dir_w[g]),
			.ramp_i(ramp_w[g]),
			.stop_hit_i(stop_hit[g]),
			.decel_req_i(decel_req[g]),
			.sudden_req_i(sudden_req[g]),
			.settle_en_i(s_q.lim_pls[g][`AMCFG_INP_EN]),
			.settled_i(settled[g]),
			.tick_i(1'b1),
			.pulse_o(pulse_w[g]),
			.busy_o(drv_busy[g]),
			.running_o(running[g])
		);
		always_comb begin
			logic p;
			p = s_q.pls_out[g] ^ s_q.lim_pls[g][`AMCFG_PLS_POL];
			if (s_q.lim_pls[g][`AMCFG_OUT_FMT]) begin
				pulse_out_a_o[g] = p;
				pulse_out_b_o[g] = s_q.dir_out[g] ^ s_q.lim_pls[g][`AMCFG_DIR_POL];
			end else begin
				pulse_out_a_o[g] = s_q.dir_out[g] ? s_q.lim_pls[g][`AMCFG_PLS_POL] : p;
				pulse_out_b_o[g] = s_q.dir_out[g] ? p : s_q.lim_pls[g][`AMCFG_PLS_POL];
			end
		end
		assign irq_src_en_o[g] = s_q.stop_irq[g][15:8];
	end

	assign avs_waitrequest = avs_read && !s_q.rvalid;
	assign avs_readdata = s_q.rdata;
	assign cmd_wait_n_o = (s_q.busy_cnt == 5'd0);
endmodule : amcfg_top
`default_nettype wire
